// ---- src/dpt_pkg.sv ----
// package: register map, field positions and reset values of the dual timer
package dpt_pkg;

    // ----------------------------------------
    // register offsets (byte addresses in data space)
    // ----------------------------------------
    localparam logic [7:0] DPT_T1_PRESCALE_OFS = 8'hD2;
    localparam logic [7:0] DPT_T1_COUNT_OFS = 8'hD3;
    localparam logic [7:0] DPT_T1_CTRL_OFS = 8'hD4;
    localparam logic [7:0] DPT_T2_PRESCALE_OFS = 8'hD5;
    localparam logic [7:0] DPT_T2_COUNT_OFS = 8'hD6;
    localparam logic [7:0] DPT_T2_CTRL_OFS = 8'hD7;

    // ----------------------------------------
    // control/status field positions
    // ----------------------------------------
    localparam int DPT_ZERO_FLAG_BIT = 7;
    localparam int DPT_ZERO_IRQ_EN_BIT = 6;
    localparam int DPT_RSVD5_BIT = 5;
    localparam int DPT_SPARE4_BIT = 4;
    localparam int DPT_RUN_BIT = 3;
    localparam int DPT_TAP_MSB = 2;

    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic [7:0] DPT_COUNT_RST = 8'hFF;
    localparam logic [6:0] DPT_PRESCALE_RST = 7'h7F;
    localparam logic [7:0] DPT_CTRL_RST = 8'h00;
    localparam logic [7:0] DPT_COUNT_ZERO = 8'h00;
    localparam int DPT_PRE_DIV = 12;
    localparam logic [3:0] DPT_PRE_DIV_LAST = 4'(DPT_PRE_DIV - 1);

    // one timer's state
    typedef struct packed {
        logic [7:0] count;
        logic [6:0] prescale;
        logic [7:0] ctrl;
    } dpt_unit_s;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dpt_req_s;

endpackage : dpt_pkg

// ---- src/dpt_timer.sv ----
// module: two prescaled 8-bit down timers with register port
// How it works
// - two independent timers, each 8-bit counter plus 7-bit programmable prescaler
// - counter decrements on each rising edge of selected tap; software loads and reads
// - counting down to zero sets zero_flag, bit 7 of control/status
// - interrupt request when zero_irq_enable (bit 6) and zero_flag both one
// - prescaler counts down on rising edge of clock divided by twelve
// - ratio one uses prescaler input clock; ratio two bit 0, four bit 1
// - tap_select bits 2..0 pick ratios 1 through 128
// - prescaler_run low forces prescaler 7Fh and stops both counting
// - with prescaler_run high software may load prescaler 0..7Fh
// - writing 00h to counter or one to bit 7 sets zero_flag
// - reset: counter FFh, prescaler 7Fh, control/status zero
// - counter write beats simultaneous decrement to zero; flag stays clear
// - counter and prescaler read back their live values at any time
// - prescaler register bit 7 reads zero
// - active request doubles as wake-up from low-power wait
`timescale 1ns/1ps
`default_nettype none

module dpt_timer
    import dpt_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic [1:0] irq_o,
    output logic wake_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------

    // tap level for a selection; sel 0 is the divided clock itself
    function automatic logic tap_level(input logic [2:0] sel, input logic [6:0] pre, input logic div_lvl);
        logic lvl;
        lvl = div_lvl;
        if (sel != 3'd0)
        begin
            lvl = pre[sel - 3'd1];
        end
        return lvl;
    endfunction : tap_level

    // register index decode: unit number and slot (0 prescale, 1 count, 2 ctrl)
    function automatic logic [2:0] decode(input logic [7:0] a);
        logic [2:0] r;
        r = 3'b111;
        if (a == DPT_T1_PRESCALE_OFS)
        begin
            r = 3'b000;
        end
        else if (a == DPT_T1_COUNT_OFS)
        begin
            r = 3'b001;
        end
        else if (a == DPT_T1_CTRL_OFS)
        begin
            r = 3'b010;
        end
        else if (a == DPT_T2_PRESCALE_OFS)
        begin
            r = 3'b100;
        end
        else if (a == DPT_T2_COUNT_OFS)
        begin
            r = 3'b101;
        end
        else if (a == DPT_T2_CTRL_OFS)
        begin
            r = 3'b110;
        end
        return r;
    endfunction : decode

    // ----------------------------------------
    // divide-by-twelve prescaler clock
    // ----------------------------------------
    logic [3:0] div_q;
    logic [3:0] div_d;
    logic div_lvl_q;
    logic div_lvl_d;
    logic div_rise;

    // divided clock: high for six cycles, low for six; rise at wrap
    always_comb
    begin
        div_rise = (div_q == DPT_PRE_DIV_LAST);
        div_d = div_rise ? 4'd0 : div_q + 4'd1;
        div_lvl_d = (div_d < 4'(DPT_PRE_DIV / 2));
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            div_q <= 4'd0;
            div_lvl_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            div_lvl_q <= div_lvl_d;
        end
    end

    // ----------------------------------------
    // timer units
    // ----------------------------------------
    dpt_unit_s unit_q [2];
    dpt_unit_s unit_d [2];
    logic [1:0] tap_q;
    logic [1:0] tap_d;
    logic [1:0] irq_d;
    logic [2:0] wsel;
    logic [1:0] run;
    logic [1:0] pre_en;
    logic [1:0] wr_pre;
    logic [1:0] wr_cnt;
    logic [1:0] wr_ctl;
    logic [6:0] pre_next [2];
    logic [1:0] tap_now;
    logic [1:0] cnt_en;
    logic [1:0] zero_hit;
    logic [1:0] zero_load;
    logic wake_d;

    // write decode and run state of each unit
    always_comb
    begin
        wsel = decode(addr_i);
        for (int u = 0; u < 2; u++)
        begin
            wr_pre[u] = wr_i && (wsel == {1'(u), 2'd0});
            wr_cnt[u] = wr_i && (wsel == {1'(u), 2'd1});
            wr_ctl[u] = wr_i && (wsel == {1'(u), 2'd2});
            run[u] = unit_q[u].ctrl[DPT_RUN_BIT];
            pre_en[u] = run[u] && div_rise;
        end
    end

    // ----------------------------------------
    // prescalers
    // ----------------------------------------

    // forced while stopped, else load or count down with wrap
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            pre_next[u] = unit_q[u].prescale;
            if (!run[u])
            begin
                pre_next[u] = DPT_PRESCALE_RST;
            end
            else if (wr_pre[u])
            begin
                pre_next[u] = wdata_i[6:0];
            end
            else if (pre_en[u])
            begin
                pre_next[u] = unit_q[u].prescale - 7'd1;
            end
        end
    end

    // ----------------------------------------
    // counter clock taps
    // ----------------------------------------

    // tap level after this cycle's update, edge found against last level
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            tap_now[u] = tap_level(unit_q[u].ctrl[DPT_TAP_MSB:0], pre_next[u], div_lvl_d);
            tap_d[u] = run[u] ? tap_now[u] : 1'b0;
            cnt_en[u] = run[u] && tap_now[u] && !tap_q[u];
        end
    end

    // edge detector state, cleared while a unit is stopped
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tap_q <= 2'b00;
        end
        else
        begin
            tap_q <= tap_d;
        end
    end

    // ----------------------------------------
    // counters and zero flags
    // ----------------------------------------

    // zero events: a decrement from one, or software loading zero
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            zero_hit[u] = !wr_cnt[u] && cnt_en[u] && (unit_q[u].count == 8'd1);
            zero_load[u] = wr_cnt[u] && (wdata_i == DPT_COUNT_ZERO);
        end
    end

    // counter write wins over decrement; hardware flag set beats a software clear
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            unit_d[u] = unit_q[u];
            unit_d[u].prescale = pre_next[u];
            if (wr_cnt[u])
            begin
                unit_d[u].count = wdata_i;
            end
            else if (cnt_en[u])
            begin
                unit_d[u].count = unit_q[u].count - 8'd1;
            end
            if (wr_ctl[u])
            begin
                unit_d[u].ctrl = wdata_i;
            end
            if (zero_hit[u] || zero_load[u])
            begin
                unit_d[u].ctrl[DPT_ZERO_FLAG_BIT] = 1'b1;
            end
        end
    end

    // unit registers with documented reset state
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int u = 0; u < 2; u++)
            begin
                unit_q[u].count <= DPT_COUNT_RST;
                unit_q[u].prescale <= DPT_PRESCALE_RST;
                unit_q[u].ctrl <= DPT_CTRL_RST;
            end
        end
        else
        begin
            for (int u = 0; u < 2; u++)
            begin
                unit_q[u] <= unit_d[u];
            end
        end
    end

    // ----------------------------------------
    // interrupt requests and wake-up
    // ----------------------------------------

    // request per unit from next flag and enable, wake from either
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            irq_d[u] = unit_d[u].ctrl[DPT_ZERO_FLAG_BIT] && unit_d[u].ctrl[DPT_ZERO_IRQ_EN_BIT];
        end
        wake_d = |irq_d;
    end

    // registered so both outputs come straight from flip-flops
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            irq_o <= 2'b00;
            wake_o <= 1'b0;
        end
        else
        begin
            irq_o <= irq_d;
            wake_o <= wake_d;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    logic [7:0] rdata_d;
    logic [2:0] rsel;

    // live values, data in the cycle after the strobe, zero otherwise
    always_comb
    begin
        rsel = decode(addr_i);
        rdata_d = 8'h00;
        if (rd_i)
        begin
            if (rsel == 3'b000)
            begin
                rdata_d = {1'b0, unit_q[0].prescale};
            end
            else if (rsel == 3'b001)
            begin
                rdata_d = unit_q[0].count;
            end
            else if (rsel == 3'b010)
            begin
                rdata_d = unit_q[0].ctrl;
            end
            else if (rsel == 3'b100)
            begin
                rdata_d = {1'b0, unit_q[1].prescale};
            end
            else if (rsel == 3'b101)
            begin
                rdata_d = unit_q[1].count;
            end
            else if (rsel == 3'b110)
            begin
                rdata_d = unit_q[1].ctrl;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else
        begin
            rdata_o <= rdata_d;
        end
    end

endmodule : dpt_timer

`default_nettype wire

// ---- dv/dpt_timer_asserts.sv ----
// checker: port-level assertions of the dual timer
`timescale 1ns/1ps
`default_nettype none
module dpt_timer_asserts
    import dpt_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] irq_o,
    input wire logic wake_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    logic run1_q;
    logic run1_d;
    // shadow of timer1 run bit, only writes change it
    always_comb run1_d = (wr_i && addr_i == DPT_T1_CTRL_OFS) ? wdata_i[DPT_RUN_BIT] : run1_q;
    always_ff @(posedge clk_i or negedge arst_n_i)
        if (!arst_n_i)
            run1_q <= 1'b0;
        else
            run1_q <= run1_d;
    // control write of flag and enable, then a quiet cycle
    sequence s_ctl(a, v);
        wr_i && addr_i == a && wdata_i[7:6] == v ##1 !(wr_i && addr_i == a);
    endsequence
    a_psc_bit7: assert property (rd_i && (addr_i == DPT_T1_PRESCALE_OFS || addr_i == DPT_T2_PRESCALE_OFS)
        |=> !rdata_o[7]) else $error("prescaler bit7 set");
    a_stop_psc: assert property (rd_i && addr_i == DPT_T1_PRESCALE_OFS && !run1_q && !$past(run1_q)
        |=> rdata_o == 8'h7F) else $error("stopped prescaler not 7F");
    a_ctrl_back: assert property (wr_i && addr_i == DPT_T1_CTRL_OFS && wdata_i[7] == 1'b0 && !wdata_i[3] && !run1_q
        ##1 rd_i && addr_i == DPT_T1_CTRL_OFS |=> rdata_o == $past(wdata_i, 2)) else $error("ctrl readback");
    a_flag_irq1: assert property (s_ctl(DPT_T1_CTRL_OFS, 2'b11) |=> irq_o[0])
        else $error("timer1 irq missing");
    a_flag_irq2: assert property (s_ctl(DPT_T2_CTRL_OFS, 2'b11) |=> irq_o[1])
        else $error("timer2 irq missing");
    a_irq_off: assert property (s_ctl(DPT_T1_CTRL_OFS, 2'b00) |=> !irq_o[0])
        else $error("timer1 irq not cleared");
    a_wake_any: assert property (wake_o |-> (|irq_o) || $past(|irq_o))
        else $error("wake without request");
    a_wake_hold: assert property ((|irq_o) && $past(|irq_o) |-> wake_o)
        else $error("request without wake");
endmodule : dpt_timer_asserts
`default_nettype wire

// ---- dv/tb.sv ----
// testbench: registers, flags and requests of the dual timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dpt_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [1:0] irq_o;
    logic wake_o;
    logic [7:0] r;
    logic [7:0] a_r;
    logic [7:0] p_r;
    int n_mismatch = 0;
    int compares = 0;
    // rows: address, write data, read-back value
    logic [23:0] rows [6] = '{24'hD3_0505, 24'hD6_A5A5, 24'hD4_2525, 24'hD2_157F, 24'hD0_AA00, 24'hD7_2727};
    dpt_timer u_dpt_timer (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .wake_o);
    initial forever #12.5 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 r = rdata_o;
        @(posedge clk_i);
    endtask : rd
    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // main sequence: table, flag cases, reset, count rate
    initial
    begin
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (rows[i])
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chk(r, rows[i][7:0]);
        end
        $display("table done");
        wr(DPT_T1_COUNT_OFS, 8'h02);
        wr(DPT_T1_CTRL_OFS, 8'h68);
        idle(40);
        chk({6'h00, irq_o}, 8'h01);
        chk({7'h00, wake_o}, 8'h01);
        wr(DPT_T1_CTRL_OFS, 8'h20);
        idle(2);
        chk({6'h00, irq_o}, 8'h00);
        rd(DPT_T1_PRESCALE_OFS);
        chk(r, 8'h7F);
        wr(DPT_T1_CTRL_OFS, 8'hE0);
        wr(DPT_T2_CTRL_OFS, 8'hE0);
        idle(2);
        chk({6'h00, irq_o}, 8'h03);
        wr(DPT_T2_CTRL_OFS, 8'h60);
        wr(DPT_T2_COUNT_OFS, 8'h00);
        idle(2);
        chk({6'h00, irq_o}, 8'h03);
        $display("flag tests done");
        arst_n_i <= 1'b0;
        idle(2);
        chk({5'h00, irq_o, wake_o}, 8'h00);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 6; i++)
        begin
            rd(DPT_T1_PRESCALE_OFS + 8'(i));
            chk(r, (i % 3 == 0) ? 8'h7F : (i % 3 == 1) ? 8'hFF : 8'h00);
        end
        $display("reset test done");
        wr(DPT_T1_CTRL_OFS, 8'h28);
        wr(DPT_T1_COUNT_OFS, 8'h05);
        wr(DPT_T1_PRESCALE_OFS, 8'h40);
        rd(DPT_T1_PRESCALE_OFS);
        chk(r, 8'h40);
        rd(DPT_T1_COUNT_OFS);
        a_r = r;
        rd(DPT_T1_PRESCALE_OFS);
        p_r = r;
        idle(116);
        rd(DPT_T1_COUNT_OFS);
        chk(a_r - r, 8'h0A);
        rd(DPT_T1_PRESCALE_OFS);
        chk((p_r - r) & 8'h7F, 8'h0A);
        wr(DPT_T2_CTRL_OFS, 8'h29);
        idle(2);
        rd(DPT_T2_COUNT_OFS);
        a_r = r;
        idle(238);
        rd(DPT_T2_COUNT_OFS);
        chk(a_r - r, 8'h0A);
        $display("count rate test done");
        conclude();
    end
    // watchdog far beyond the few hundred cycles needed
    initial
    begin
        #100us;
        n_mismatch++;
        conclude();
    end
endmodule : tb
bind dpt_timer dpt_timer_asserts u_dpt_timer_asserts (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .irq_o, .wake_o);
`default_nettype wire
